// file: common/isp_pkg.sv
package isp_pkg;

  // ----------------------------------------------------------------
  // bus framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT  = 4'h1;
  localparam int         RW_BIT        = 0;
  localparam int         SEL_MSB       = 6;
  localparam int         SEL_LSB       = 3;
  localparam int         TX_MSB        = 7;

  // ----------------------------------------------------------------
  // slave address: base plus strap offset
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE7    = 7'h48;
  localparam logic [1:0] STRAP_VDD     = 2'h0;
  localparam logic [1:0] STRAP_GND     = 2'h1;
  localparam logic [1:0] STRAP_SCL     = 2'h2;
  localparam logic [1:0] STRAP_SDA     = 2'h3;
  localparam logic [6:0] ADDR_RST7     = 7'h48;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_FREE_NS   = 1300;
  localparam int BUS_FREE_CYC  = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // transfer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_SUB   = 4'h3,
    ST_SACK  = 4'h4,
    ST_WDATA = 4'h5,
    ST_WACK  = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK  = 4'h8,
    ST_SKIP  = 4'h9
  } isp_state_t;

endpackage

// file: common/isp_line_if.sv
`timescale 1ns/1ps
interface isp_line_if;
  logic scl_h;
  logic sda_h;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  modport src (output scl_h, output sda_h, output scl_rise, output scl_fall,
               output start_ev, output stop_ev);
  modport dst (input scl_h, input sda_h, input scl_rise, input scl_fall,
               input start_ev, input stop_ev);
endinterface

// file: src/isp_line_sync.sv
`timescale 1ns/1ps
module isp_line_sync
  import isp_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  // bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // conditioned line events
  isp_line_if.src   ln
);

  // ----------------------------------------------------------------
  // two-flop synchronisers, index 0 scl, index 1 sda
  // ----------------------------------------------------------------
  logic [1:0] pin;
  logic [1:0] meta;
  logic [1:0] stab;
  logic [1:0] prev;

  assign pin = {sda_in, scl_in};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_sync
      // idle bus is high, so reset to high avoids a false start
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta[i] <= 1'b1;
          stab[i] <= 1'b1;
          prev[i] <= 1'b1;
        end else if (clk_en) begin
          meta[i] <= pin[i];
          stab[i] <= meta[i];
          prev[i] <= stab[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge and condition decode
  // ----------------------------------------------------------------
  wire scl_steady_high = stab[0] && prev[0];

  assign ln.scl_h    = stab[0];
  assign ln.sda_h    = stab[1];
  assign ln.scl_rise = stab[0] && !prev[0];
  assign ln.scl_fall = !stab[0] && prev[0];
  assign ln.start_ev = scl_steady_high && prev[1] && !stab[1];
  assign ln.stop_ev  = scl_steady_high && !prev[1] && stab[1];

endmodule

// file: src/isp_addr_strap.sv
`timescale 1ns/1ps
module isp_addr_strap
  import isp_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // sensed strap codes
  input  wire logic [1:0] addr_strap_upper,
  input  wire logic [1:0] addr_strap_lower,
  // resulting 7-bit address
  output logic      [6:0] own_addr
);

  logic [3:0] meta;
  logic [3:0] stab;

  // codes are static, but still cross in through two flops
  wire [6:0] next_own_addr = ADDR_BASE7 + {3'h0, stab};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta     <= 4'h0;
      stab     <= 4'h0;
      own_addr <= ADDR_RST7;
    end else if (clk_en) begin
      meta     <= {addr_strap_upper, addr_strap_lower};
      stab     <= meta;
      own_addr <= next_own_addr;
    end
  end

endmodule

// file: src/isp_slave_port.sv
`timescale 1ns/1ps
// How it works
// - sda falling while scl high is a start and opens a new transaction.
// - sda rising while scl high is a stop and ends the transaction.
// - bus is busy from start until a free interval after stop.
// - transmitter changes sda only while scl is low; receiver samples on rise.
// - bytes are eight bits, msb first, each followed by an acknowledge slot.
// - acknowledger pulls sda low in the slot; byte sender releases sda.
// - slave acknowledges address, sub-address and every written data byte.
// - first byte holds seven address bits then direction, 0 write, 1 read.
// - on address match the slave acknowledges and takes the selected direction.
// - strap codes give address 0x90 plus twice (4 x upper + lower).
// - after a write address comes a sub-address byte, also acknowledged.
// - register select is sub-address bits 6:3; bits 7 and 2:0 ignored.
// - written bytes go to the selected register then successive ones.
// - no limit on the number of bytes in a transfer.
// - reads use sub-address write, repeated start, then read address.
// - repeated start without stop begins a new addressed transfer.
module isp_slave_port
  import isp_pkg::*;
#(
  parameter int BUS_FREE_CYCLES = BUS_FREE_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address straps
  input  wire logic [1:0] addr_strap_upper,
  input  wire logic [1:0] addr_strap_lower,
  // register side
  output logic      [3:0] reg_sel,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  // status
  output logic            bus_busy
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (BUS_FREE_CYCLES < 1 || BUS_FREE_CYCLES > 65535) begin : g_bad_free
      $error("BUS_FREE_CYCLES must lie in 1..65535");
    end
  endgenerate

  localparam logic [15:0] FREE_LOAD = 16'(BUS_FREE_CYCLES);

  // ----------------------------------------------------------------
  // line conditioning and address
  // ----------------------------------------------------------------
  isp_line_if ln ();
  logic [6:0] own_addr;

  isp_line_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_en  (clk_en),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ln      (ln)
  );

  isp_addr_strap u_strap (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .clk_en           (clk_en),
    .addr_strap_upper (addr_strap_upper),
    .addr_strap_lower (addr_strap_lower),
    .own_addr         (own_addr)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  isp_state_t  st;
  logic [3:0]  cnt;
  logic [7:0]  shift;
  logic [7:0]  tx;
  logic        rw;
  logic        macked;
  logic [15:0] free_cnt;

  isp_state_t  next_st;
  logic [3:0]  next_cnt;
  logic [7:0]  next_shift;
  logic [7:0]  next_tx;
  logic        next_rw;
  logic        next_macked;
  logic        next_oe;
  logic [3:0]  next_sel;
  logic        next_wr;
  logic [7:0]  next_wdata;
  logic        next_rd;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire rx_state  = (st == ST_ADDR) || (st == ST_SUB) || (st == ST_WDATA);
  wire byte_full = (cnt == BYTE_BITS);
  wire rx_bit    = rx_state && ln.scl_rise && !byte_full;
  wire byte_done = rx_state && ln.scl_fall && byte_full;
  wire addr_hit  = (shift[7:1] == own_addr);
  wire load_rd   = ln.scl_fall && (((st == ST_AACK) && rw) || ((st == ST_RACK) && macked));
  wire [3:0] sel_inc = reg_sel + 4'h1;
  wire [3:0] cnt_inc = cnt + 4'h1;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_shift  = shift;
    next_tx     = tx;
    next_rw     = rw;
    next_macked = macked;
    next_oe     = sda_oe;
    next_sel    = reg_sel;
    next_wr     = 1'b0;
    next_wdata  = reg_wdata;
    next_rd     = 1'b0;
    if (ln.start_ev) begin
      // a repeated start lands here too, whatever the state
      next_st  = ST_ADDR;
      next_cnt = 4'h0;
      next_oe  = 1'b0;
    end else if (ln.stop_ev) begin
      next_st = ST_IDLE;
      next_oe = 1'b0;
    end else if (load_rd) begin
      // fetch on the ack-slot fall so the msb is out before the next rise
      next_tx  = reg_rdata;
      next_oe  = !reg_rdata[TX_MSB];
      next_rd  = 1'b1;
      next_cnt = FIRST_TX_BIT;
      next_st  = ST_RDATA;
    end else begin
      if (rx_bit) begin
        next_shift = {shift[6:0], ln.sda_h};
        next_cnt   = cnt_inc;
      end
      case (st)
        ST_IDLE: begin
          next_oe = 1'b0;
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              next_oe = 1'b1;
              next_rw = shift[RW_BIT];
              next_st = ST_AACK;
            end else begin
              next_st = ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          if (ln.scl_fall) begin
            next_oe  = 1'b0;
            next_cnt = 4'h0;
            next_st  = ST_SUB;
          end
        end
        ST_SUB: begin
          if (byte_done) begin
            next_sel = shift[SEL_MSB:SEL_LSB];
            next_oe  = 1'b1;
            next_st  = ST_SACK;
          end
        end
        ST_SACK, ST_WACK: begin
          if (ln.scl_fall) begin
            next_oe  = 1'b0;
            next_cnt = 4'h0;
            next_st  = ST_WDATA;
            if (st == ST_WACK) begin
              next_sel = sel_inc;
            end
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            next_wdata = shift;
            next_wr    = 1'b1;
            next_oe    = 1'b1;
            next_st    = ST_WACK;
          end
        end
        ST_RDATA: begin
          if (ln.scl_fall) begin
            if (byte_full) begin
              next_oe = 1'b0;
              next_st = ST_RACK;
            end else begin
              next_oe  = !tx[TX_MSB - 1];
              next_tx  = {tx[6:0], 1'b0};
              next_cnt = cnt_inc;
            end
          end
        end
        ST_RACK: begin
          if (ln.scl_rise) begin
            next_macked = !ln.sda_h;
            if (!ln.sda_h) begin
              next_sel = sel_inc;
            end
          end else if (ln.scl_fall) begin
            next_st = ST_SKIP;
          end
        end
        ST_SKIP: begin
          next_oe = 1'b0;
        end
        default: begin
          next_st = ST_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st        <= ST_IDLE;
      cnt       <= 4'h0;
      shift     <= 8'h00;
      tx        <= 8'h00;
      rw        <= 1'b0;
      macked    <= 1'b0;
      sda_oe    <= 1'b0;
      reg_sel   <= 4'h0;
      reg_wr    <= 1'b0;
      reg_wdata <= 8'h00;
      reg_rd    <= 1'b0;
    end else if (clk_en) begin
      st        <= next_st;
      cnt       <= next_cnt;
      shift     <= next_shift;
      tx        <= next_tx;
      rw        <= next_rw;
      macked    <= next_macked;
      sda_oe    <= next_oe;
      reg_sel   <= next_sel;
      reg_wr    <= next_wr;
      reg_wdata <= next_wdata;
      reg_rd    <= next_rd;
    end
  end

  // open drain: only ever pulls low, never originates start or stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus busy
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_busy <= 1'b0;
      free_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (ln.start_ev) begin
        bus_busy <= 1'b1;
        free_cnt <= 16'h0000;
      end else if (ln.stop_ev) begin
        free_cnt <= FREE_LOAD;
      end else if (free_cnt != 16'h0000) begin
        free_cnt <= free_cnt - 16'h0001;
        if (free_cnt == 16'h0001) begin
          bus_busy <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_START_OPENS: assert property (clk_en && ln.start_ev |=> st == ST_ADDR && !sda_oe)
    else $error("start did not open address phase");
  AST_STOP_ENDS: assert property (clk_en && ln.stop_ev && !ln.start_ev
      |=> st == ST_IDLE)
    else $error("stop did not end transaction");
  AST_BUSY_START: assert property (clk_en && ln.start_ev |=> bus_busy [*2])
    else $error("bus not busy after start");
  AST_OE_ONLY_SCL_LOW: assert property ($changed(sda_oe) |->
      !$past(ln.scl_h) || $past(ln.start_ev) || $past(ln.stop_ev))
    else $error("sda drive changed while scl high");
  AST_MSB_FIRST: assert property (reg_rd |-> sda_oe == !tx[TX_MSB] && st == ST_RDATA)
    else $error("read byte did not start with msb");
  AST_ADDR_ACK: assert property (clk_en && st == ST_ADDR && byte_done && addr_hit
      && !ln.start_ev && !ln.stop_ev |=> sda_oe && st == ST_AACK)
    else $error("matching address not acknowledged");
  AST_WR_ACK: assert property (reg_wr |-> sda_oe && st == ST_WACK)
    else $error("write byte stored without acknowledge");
  AST_SUB_SEL: assert property (clk_en && st == ST_SUB && byte_done
      && !ln.start_ev && !ln.stop_ev |=> reg_sel == $past(shift[SEL_MSB:SEL_LSB]))
    else $error("register select not taken from sub-address");
  AST_SKIP_QUIET: assert property (st == ST_SKIP |-> !sda_oe)
    else $error("sda driven after mismatch");

endmodule

// file: verification/isp_master_model.sv
`timescale 1ns/1ps
module isp_master_model (
  // bus pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ------------------------------------------------------------
  // link timing: four quarters make one 124 ns bit
  // ------------------------------------------------------------
  localparam int QTR = 31;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ------------------------------------------------------------
  // bus conditions
  // ------------------------------------------------------------
  // release data first so a repeated start also works after an ack
  task automatic start_cond();
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1; // only this side makes start
    #QTR scl = 1'b0;
  endtask

  task automatic stop_cond();
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0; // only this side makes stop
    #QTR;
  endtask

  // data moves only while scl is low
  task automatic clock_bit(input logic b, output logic seen);
    #QTR sda_low = ~b;
    #QTR scl = 1'b1;
    #QTR seen = sda;
    #QTR scl = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s); // msb first
    end
    clock_bit(1'b1, s); // released, slot still clocked
    ack = ~s;
  endtask

  task automatic read_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(last, s); // ack all but the last byte
  endtask
endmodule

// file: verification/isp_slave_port_bench.sv
`timescale 1ns/1ps
module isp_slave_port_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int FREE = 4;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [1:0]  strap_up = 2'h0;
  logic [1:0]  strap_lo = 2'h0;
  logic        scl;
  logic        m_low;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic        reg_wr;
  logic        reg_rd;
  logic        bus_busy;
  logic [3:0]  reg_sel;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  regs [16];
  logic [11:0] exp_q [$];
  int          fails = 0;
  int          checks = 0;
  int          rd_cnt = 0;
  int          seed = 12654;

  always #5 clk_sys = ~clk_sys;

  // pull-up wire: low when either party pulls
  assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
  assign reg_rdata = regs[reg_sel];

  isp_slave_port #(.BUS_FREE_CYCLES(FREE)) i_isp_slave_port (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .clk_en           (clk_en),
    .scl_in           (scl),
    .sda_in           (sda),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .addr_strap_upper (strap_up),
    .addr_strap_lower (strap_lo),
    .reg_sel          (reg_sel),
    .reg_wr           (reg_wr),
    .reg_wdata        (reg_wdata),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .bus_busy         (bus_busy)
  );

  isp_master_model i_isp_master_model (
    .scl     (scl),
    .sda_low (m_low),
    .sda     (sda)
  );

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a write with no note queued compares against unknown and fails
  always @(posedge clk_sys) begin
    if (reg_wr === 1'b1) begin
      check("write", {reg_sel, reg_wdata},
            exp_q.size() > 0 ? exp_q.pop_front() : 12'hxxx);
      regs[reg_sel] <= reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      rd_cnt++;
    end
  end

  initial begin
    #500_000;
    fails++;
    finish_test();
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  task automatic end_frame();
    check("busy", 12'(bus_busy), 12'h001);
    i_isp_master_model.stop_cond();
    check("busy after stop", 12'(bus_busy), 12'h001);
    // a low enable must hold the free countdown where it stands
    @(posedge clk_sys);
    #1 clk_en = 1'b0;
    repeat (20) @(posedge clk_sys);
    check("frozen busy", 12'(bus_busy), 12'h001);
    #1 clk_en = 1'b1;
    for (int k = 0; k < 40 && bus_busy !== 1'b0; k++) begin
      @(posedge clk_sys);
    end
    check("free", 12'(bus_busy), 12'h000);
  endtask

  initial begin
    logic       ack;
    logic [7:0] b;
    logic [7:0] sa;
    logic [7:0] sub;
    logic [3:0] sel;
    logic [7:0] w [3];
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'($random(seed));
    end
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    // every strap pair; the neighbour address must be ignored
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      #1 {strap_up, strap_lo} = 4'(i);
      repeat (10) @(posedge clk_sys);
      sa = 8'h90 + 8'(2 * i);
      i_isp_master_model.start_cond();
      i_isp_master_model.write_byte(sa, ack);
      check("addr ack", 12'(ack), 12'h001);
      i_isp_master_model.start_cond();
      i_isp_master_model.write_byte(sa ^ 8'h02, ack);
      check("other addr", 12'(ack), 12'h000);
      i_isp_master_model.write_byte(8'($random(seed)), ack);
      check("silent", 12'(ack), 12'h000);
      end_frame();
    end
    @(posedge clk_sys);
    #1 {strap_up, strap_lo} = 4'($random(seed));
    repeat (10) @(posedge clk_sys);
    sa = 8'h90 + {3'h0, strap_up, strap_lo, 1'b0};
    // burst write then read back through a repeated start
    for (int n = 0; n < 2; n++) begin
      sel = 4'hA + 4'(n);
      sub = {1'b1, sel, 3'b001}; // stray bits set on purpose
      i_isp_master_model.start_cond();
      i_isp_master_model.write_byte(sa, ack);
      check("addr ack", 12'(ack), 12'h001);
      i_isp_master_model.write_byte(sub, ack);
      check("sub ack", 12'(ack), 12'h001);
      for (int k = 0; k < 3; k++) begin
        w[k] = 8'($random(seed));
        exp_q.push_back({sel + 4'(k), w[k]});
        i_isp_master_model.write_byte(w[k], ack);
        check("data ack", 12'(ack), 12'h001);
      end
      check("writes seen", 12'(exp_q.size()), 12'h000);
      i_isp_master_model.start_cond();
      i_isp_master_model.write_byte(sa, ack);
      i_isp_master_model.write_byte(sub, ack);
      i_isp_master_model.start_cond();
      i_isp_master_model.write_byte(sa | 8'h01, ack);
      check("read addr ack", 12'(ack), 12'h001);
      rd_cnt = 0;
      for (int k = 0; k < 3; k++) begin
        i_isp_master_model.read_byte(k == 2, b);
        check("read data", 12'(b), 12'(w[k]));
      end
      check("fetches", 12'(rd_cnt), 12'h003);
      end_frame();
    end
    finish_test();
  end
endmodule
